// file: shared/pwx_defs.svh
`ifndef PWX_DEFS_SVH
`define PWX_DEFS_SVH
// ==========================================
// Counter geometry
`define PWX_PERIOD_COUNT 8'h80
`define PWX_CNT_RESET 8'h00
`define PWX_DUTY_RESET 7'h00
// ==========================================
// Prescaler tap exponents per clock select code
`define PWX_TAP_SEL0 11
`define PWX_TAP_SEL1 10
`define PWX_TAP_SEL2 8
`define PWX_TAP_SEL3 6
`define PWX_TAP_SEL4 4
`define PWX_TAP_SEL5 2
`define PWX_TAP_SEL6 1
`define PWX_PRESCALE_WIDTH 11
`endif

// file: shared/pwx_pkg.sv
package pwx_pkg;
  typedef logic [2:0] pwx_clk_sel_t;
  typedef logic [6:0] pwx_duty_t;
  typedef enum logic [1:0] {
    PWX_IDLE,
    PWX_RUN
  } pwx_state_t;
endpackage

// file: verilog/pwx_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwx_defs.svh"
// Prescaler, cleared while i_run is low, that yields a one-cycle tick at the chosen rate
module pwx_prescaler
  import pwx_pkg::*;
#(
  parameter int WIDTH = `PWX_PRESCALE_WIDTH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire pwx_clk_sel_t i_clk_sel,
  output logic o_tick
);
  // Refuse a divider too short to reach the slowest tap
  if (WIDTH < `PWX_TAP_SEL0) begin : g_width_check
    $error("pwx_prescaler: WIDTH too small for slowest tap");
  end

  logic [WIDTH-1:0] div;

  // ==========================================
  // Divider, held at zero while stopped so the first tick has full length
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_run) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  // Tick when all bits below the tap exponent are ones
  function automatic logic tap_hit(input logic [WIDTH-1:0] d, input int e);
    logic [WIDTH-1:0] m;
    m = WIDTH'((1 << e) - 1);
    tap_hit = ((d & m) == m);
  endfunction

  logic next_tick;
  always_comb begin
    case (i_clk_sel)
      3'h0: next_tick = tap_hit(div, `PWX_TAP_SEL0);
      3'h1: next_tick = tap_hit(div, `PWX_TAP_SEL1);
      3'h2: next_tick = tap_hit(div, `PWX_TAP_SEL2);
      3'h3: next_tick = tap_hit(div, `PWX_TAP_SEL3);
      3'h4: next_tick = tap_hit(div, `PWX_TAP_SEL4);
      3'h5: next_tick = tap_hit(div, `PWX_TAP_SEL5);
      3'h6: next_tick = tap_hit(div, `PWX_TAP_SEL6);
      default: next_tick = 1'b1; // Undivided
    endcase
  end

  // ==========================================
  // tick output register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !i_run) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// file: verilog/pwx_pwm7.sv
`timescale 1ns/1ps
`default_nettype none
`include "pwx_defs.svh"
// How it works
// - Counter advances one per selected source tick while run bit set.
// - Low seven counter bits matching duty toggle output away from initial level.
// - Extra-pulse set: every second duty match toggles at duty plus one.
// - Extra-pulse clear: every duty toggle happens exactly at duty.
// - Counter at 128 wraps to zero and output returns to initial level.
// - Interrupt pulse only on even-numbered wraps.
// - Clearing run stops, zeroes counter, restores initial level.
// - Buffer enable bit chooses direct or double-buffered duty update.
// - Buffered running write goes to buffer; copied at even wrap.
// - Buffered mode readback shows buffer, not active compare value.
// - Buffered write while stopped loads buffer and active value together.
// - Unbuffered write updates active compare value at once.
// - Unbuffered duty below count gives no toggle until after wrap.
// - Unbuffered write equal to count or during stretch matches immediately.
// - Clock select picks divide by 2^11,2^10,2^8,2^6,2^4,2^2,2 or 1.
// - Duty is seven bits; extra-pulse is separate bit of same register.
// - Stopped timer drives the initial level on the output.
module pwx_pwm7
  import pwx_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_chan_run_bit,
  input wire pwx_clk_sel_t i_clock_select_field,
  input wire logic i_initial_level_bit,
  input wire logic i_buffer_enable_bit,
  input wire logic i_duty_wr,
  input wire pwx_duty_t i_duty_wdata,
  input wire logic i_extra_pulse_bit_wdata,
  output pwx_duty_t o_duty_rdata,
  output logic o_extra_pulse_bit,
  output logic [7:0] o_count,
  output logic o_running,
  output logic o_pulse_out_pin,
  output logic o_chan_irq
);
  pwx_state_t state;
  logic [7:0] count;
  pwx_duty_t duty_active;
  pwx_duty_t duty_buf;
  logic extra_pulse_bit;
  logic period_odd_done;
  logic duty_toggled;
  logic tick;
  logic running;
  logic match_now;
  logic wrap_now;
  logic even_wrap;
  logic match_ahead;
  logic [7:0] target;

  assign running = (state == PWX_RUN);

  // ==========================================
  // Source clock
  // prescaled source tick
  pwx_prescaler #(
    .WIDTH(`PWX_PRESCALE_WIDTH)
  ) u_prescaler (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(running),
    .i_clk_sel(i_clock_select_field),
    .o_tick(tick)
  );

  // ==========================================
  // Run control
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= PWX_IDLE;
    end else begin
      case (state)
        PWX_IDLE: if (i_chan_run_bit) begin
          state <= PWX_RUN;
        end
        PWX_RUN: if (!i_chan_run_bit) begin
          state <= PWX_IDLE;
        end
        default: state <= PWX_IDLE;
      endcase
    end
  end

  // ==========================================
  // Match target: even-numbered period (period_odd_done set) with extra pulse waits one count more
  // stretched compare point
  always_comb begin
    target = {1'b0, duty_active};
    if (extra_pulse_bit && period_odd_done) begin
      target = {1'b0, duty_active} + 8'h01;
    end
    match_now = (count == target);
    // Look one tick ahead so the edge lands on the count change itself
    match_ahead = tick && !wrap_now && ((count + 8'h01) == target);
  end

  // Counter reaches 128 on this tick
  assign wrap_now = tick && (count == (`PWX_PERIOD_COUNT - 8'h01));
  assign even_wrap = wrap_now && period_odd_done;

  // ==========================================
  // Up counter
  // count on tick
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !running) begin
      count <= `PWX_CNT_RESET;
    end else if (wrap_now) begin
      count <= `PWX_CNT_RESET;
    end else if (tick) begin
      count <= count + 8'h01;
    end
  end

  // ==========================================
  // Period parity; cleared at stop so the first period is odd
  // parity flag
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !running) begin
      period_odd_done <= 1'b0;
    end else if (wrap_now) begin
      period_odd_done <= ~period_odd_done;
    end
  end

  // ==========================================
  // Duty register and buffer
  // seven bit duty plus extra bit
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      duty_buf <= `PWX_DUTY_RESET;
      extra_pulse_bit <= 1'b0;
    end else if (i_duty_wr) begin
      duty_buf <= i_duty_wdata;
      extra_pulse_bit <= i_extra_pulse_bit_wdata;
    end
  end

  // Active compare value; a running buffered write in the even wrap cycle goes to the buffer only, the copy takes the old buffer
  // copy at even wrap
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      duty_active <= `PWX_DUTY_RESET;
    end else if (i_duty_wr && (!i_buffer_enable_bit || !running)) begin
      duty_active <= i_duty_wdata;
    end else if (i_buffer_enable_bit && even_wrap) begin
      duty_active <= duty_buf;
    end
  end

  // ==========================================
  // Output toggle; compare is level based so an unbuffered write equal to the count
  // matches at once, while a value below the count waits for the wrap
  // duty toggle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !running) begin
      duty_toggled <= 1'b0;
    end else if (wrap_now) begin
      duty_toggled <= 1'b0;
    end else if (match_ahead || match_now) begin
      duty_toggled <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pulse_out_pin <= 1'b0;
    end else if (!running) begin
      o_pulse_out_pin <= i_initial_level_bit;
    end else if (wrap_now) begin
      o_pulse_out_pin <= i_initial_level_bit;
    end else if ((match_ahead || match_now) && !duty_toggled) begin
      o_pulse_out_pin <= ~i_initial_level_bit;
    end
  end

  // ==========================================
  // Interrupt pulse
  // even wraps only
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_chan_irq <= 1'b0;
    end else begin
      o_chan_irq <= even_wrap;
    end
  end

  // ==========================================
  // Status readback
  // buffer readback
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_duty_rdata <= `PWX_DUTY_RESET;
      o_extra_pulse_bit <= 1'b0;
      o_count <= `PWX_CNT_RESET;
      o_running <= 1'b0;
    end else begin
      o_duty_rdata <= i_buffer_enable_bit ? duty_buf : duty_active;
      o_extra_pulse_bit <= extra_pulse_bit;
      o_count <= count;
      o_running <= running;
    end
  end

  // ==========================================
  // Checks
  sequence s_odd_wrap;
    wrap_now && !period_odd_done;
  endsequence

  property p_irq_even;
    @(posedge i_clk) disable iff (i_sys_rst)
      s_odd_wrap |=> !o_chan_irq;
  endproperty
  AST_IRQ_NOT_ODD: assert property (p_irq_even)
    else $error("irq raised on odd wrap");

  AST_IRQ_ON_EVEN: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    even_wrap |=> o_chan_irq)
    else $error("irq missing on even wrap");

  AST_WRAP_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (running && wrap_now && i_chan_run_bit) |=> (count == 8'h00))
    else $error("counter did not wrap to zero");

  AST_WRAP_LEVEL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (running && wrap_now && $stable(i_initial_level_bit))
      |=> (o_pulse_out_pin == i_initial_level_bit))
    else $error("output not back at initial level after wrap");

  AST_STOP_CLEAR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (running && !i_chan_run_bit) |=> ##1 (count == 8'h00 && !period_odd_done))
    else $error("stop did not clear counter");

  AST_IDLE_LEVEL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!running && !$past(running) && !$past(i_sys_rst))
      |-> (o_pulse_out_pin == $past(i_initial_level_bit)))
    else $error("idle output not at initial level");

  AST_COUNT_STEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (running && i_chan_run_bit && tick && !wrap_now) |=> (count == $past(count) + 8'h01))
    else $error("counter did not advance on tick");

  AST_HOLD_NO_TICK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (running && i_chan_run_bit && !tick) |=> $stable(count))
    else $error("counter moved without tick");

  AST_BUF_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (running && i_buffer_enable_bit && !even_wrap && !(i_duty_wr && !running))
      |=> $stable(duty_active))
    else $error("active duty changed outside even wrap");

  AST_STOP_LOAD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_duty_wr && !running) |=> (duty_active == $past(i_duty_wdata)
      && duty_buf == $past(i_duty_wdata)))
    else $error("stopped write did not load both");

  AST_DIRECT_LOAD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_duty_wr && !i_buffer_enable_bit) |=> (duty_active == $past(i_duty_wdata)))
    else $error("unbuffered write not applied");

  AST_TOGGLE_AWAY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (running && i_chan_run_bit && (match_ahead || match_now) && !duty_toggled && !wrap_now
      && $stable(i_initial_level_bit)) |=> (o_pulse_out_pin == !i_initial_level_bit))
    else $error("duty match did not toggle output");
endmodule
`default_nettype wire

// file: tb/pwx_pin_load.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Pin load: times the high phases seen on the pulse output
module pwx_pin_load (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_pin,
  output logic [15:0] o_high_len,
  output logic [15:0] o_falls
);
  logic [15:0] run_len;
  logic prev;
  // Count high cycles; latch the length on each falling edge
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      prev <= 1'b0;
      run_len <= 16'h0000;
      o_high_len <= 16'h0000;
      o_falls <= 16'h0000;
    end else begin
      prev <= i_pin;
      run_len <= i_pin ? run_len + 16'h0001 : 16'h0000;
      if (prev && !i_pin) begin
        o_high_len <= run_len;
        o_falls <= o_falls + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/pwx_pwm7_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %0d seen %0d", nm, e, g); end end
module pwx_pwm7_tb;
  import pwx_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, run = 1'b0, lvl = 1'b0, buf_en = 1'b0;
  logic wr = 1'b0, wextra = 1'b0, extra_q, running, pin, irq;
  pwx_clk_sel_t sel = 3'h7;
  pwx_duty_t wdata = 7'h00, rdata;
  logic [7:0] count;
  logic [15:0] high_len, falls;
  int err_count = 0, check_count = 0, a, b;
  pwx_pwm7 i_dut (.i_clk(clk), .i_sys_rst(sys_rst), .i_chan_run_bit(run),
    .i_clock_select_field(sel), .i_initial_level_bit(lvl), .i_buffer_enable_bit(buf_en),
    .i_duty_wr(wr), .i_duty_wdata(wdata), .i_extra_pulse_bit_wdata(wextra),
    .o_duty_rdata(rdata), .o_extra_pulse_bit(extra_q), .o_count(count),
    .o_running(running), .o_pulse_out_pin(pin), .o_chan_irq(irq));
  pwx_pin_load i_load (.i_clk(clk), .i_sys_rst(sys_rst), .i_pin(pin),
    .o_high_len(high_len), .o_falls(falls));
  // Free running system clock, 100 ns
  initial begin
    forever #50 clk = ~clk;
  end
  // ==========================================
  // Shared helpers
  task automatic wrap_up();
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Stop first, then change modes, as mode writes are meant to be
  task automatic setup(input pwx_clk_sel_t s, input logic l, input logic be);
    @(posedge clk);
    run <= 1'b0;
    tick(2);
    @(posedge clk);
    sel <= s;
    lvl <= l;
    buf_en <= be;
    tick(3);
  endtask
  task automatic go(input logic r);
    @(posedge clk);
    run <= r;
    tick(2);
  endtask
  task automatic wr_duty(input pwx_duty_t d, input logic x);
    @(posedge clk);
    wr <= 1'b1;
    wdata <= d;
    wextra <= x;
    @(posedge clk);
    wr <= 1'b0;
    tick(2);
  endtask
  // Bounded waits: a hang counts as a mismatch and ends the run
  task automatic wait_fall(output int len);
    int f0, n;
    f0 = falls;
    n = 0;
    while (falls == f0 && n < 4000) begin
      tick(1);
      n++;
    end
    if (n >= 4000) begin
      err_count++;
      wrap_up();
    end
    len = high_len;
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (irq !== 1'b1 && n < 70000);
    if (n >= 70000) begin
      err_count++;
      wrap_up();
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_idle();
    setup(3'h7, 1'b1, 1'b0);
    `CHK("idle pin", 1, pin)
    setup(3'h7, 1'b0, 1'b0);
    `CHK("idle pin", 0, pin)
    `CHK("idle count", 0, count)
    `CHK("idle running", 0, running)
  endtask
  task automatic t_basic();
    wr_duty(7'h20, 1'b0);
    go(1'b1);
    `CHK("running", 1, running)
    wait_fall(a);
    b = count;
    tick(5);
    `CHK("count step", b + 5, count)
    wait_fall(a);
    `CHK("high len", 96, a)
    wait_irq(a);
    wait_irq(a);
    `CHK("irq spacing", 256, a)
    go(1'b0);
  endtask
  task automatic t_extra();
    wr_duty(7'h20, 1'b1);
    `CHK("extra bit", 1, extra_q)
    go(1'b1);
    wait_fall(a);
    wait_fall(a);
    wait_fall(b);
    `CHK("pair sum", 191, a + b)
    `CHK("short phase", 95, (a < b) ? a : b)
  endtask
  task automatic t_stop_level1();
    setup(3'h7, 1'b1, 1'b0);
    `CHK("stopped pin", 1, pin)
    `CHK("stopped count", 0, count)
    wr_duty(7'h20, 1'b0);
    go(1'b1);
    wait_irq(a);
    `CHK("first irq late", 1, a > 250)
    wait_fall(a);
    `CHK("inverted phase", 32, a)
    go(1'b0);
  endtask
  task automatic t_buffer();
    setup(3'h7, 1'b0, 1'b1);
    wr_duty(7'h0a, 1'b0);
    `CHK("stopped readback", 10, rdata)
    go(1'b1);
    wait_irq(a);
    wr_duty(7'h40, 1'b0);
    `CHK("buffer readback", 64, rdata)
    wait_fall(a);
    wait_fall(b);
    `CHK("old duty kept", 236, a + b)
    wait_fall(a);
    `CHK("new duty after irq", 64, a)
  endtask
  task automatic t_direct();
    setup(3'h7, 1'b0, 1'b0);
    wr_duty(7'h0a, 1'b0);
    go(1'b1);
    wait_fall(a);
    wr_duty(7'h40, 1'b0);
    `CHK("direct readback", 64, rdata)
    wait_fall(a);
    `CHK("direct duty", 64, a)
  endtask
  task automatic t_clk_sel();
    int sh[8] = '{0, 0, 0, 6, 4, 2, 1, 0};
    for (int s = 3; s < 8; s++) begin
      setup(s[2:0], 1'b0, 1'b0);
      go(1'b1);
      wait_irq(a);
      wait_irq(a);
      `CHK("sel irq spacing", 256 << sh[s], a)
    end
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    tick(1);
    t_idle();
    t_basic();
    t_extra();
    t_stop_level1();
    t_buffer();
    t_direct();
    t_clk_sel();
    wrap_up();
  end
endmodule
`default_nettype wire
